// ===== logic/atomic_slave.sv
`timescale 1ns/10ps
module atomic_slave
    import atomic_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int DEPTH = 64
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic aw_valid,
    output logic aw_ready,
    input wire logic [ADDR_W-1:0] aw_addr,
    input wire logic [7:0] aw_len,
    input wire logic [2:0] aw_size,
    input wire logic [5:0] aw_atop,
    input wire logic [3:0] aw_snoop,
    input wire logic aw_lock,
    input wire logic w_valid,
    output logic w_ready,
    input wire logic [63:0] w_data,
    input wire logic w_last,
    output logic b_valid,
    input wire logic b_ready,
    output logic [1:0] b_resp,
    output logic r_valid,
    input wire logic r_ready,
    output logic [63:0] r_data,
    output logic [1:0] r_resp,
    output logic r_last
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_COLLECT = 5'b00010,
        ST_EXEC = 5'b00100,
        ST_READ = 5'b01000,
        ST_RESP = 5'b10000
    } state_e;

    state_e state;
    logic [63:0] mem [DEPTH];
    logic aw_done;
    logic [ADDR_W-1:0] addr;
    logic [7:0] len;
    logic [2:0] size;
    logic [5:0] atop;
    logic [63:0] wbuf [2];
    logic [1:0] wcount;
    logic wlast_seen;
    logic [1:0] rcount;
    logic [1:0] rbeats;
    logic err;
    logic [63:0] alu_out;
    logic [5:0] lane_shift;
    logic [63:0] lane_mask;
    logic [63:0] mem_lane;
    logic [63:0] op_lane;
    logic [63:0] new_lane;
    logic [63:0] merged;
    logic [$clog2(DEPTH)-1:0] widx;

    function automatic logic is_loadlike(input logic [5:0] t);
        return (t[5:4] == ATOP_KIND_LOAD) || (t == ATOP_SWAP) || (t == ATOP_COMPARE);
    endfunction

    function automatic logic [7:0] aw_addr_hi(input logic [ADDR_W-1:0] a);
        return 8'(a >> 4);
    endfunction

    function automatic logic [63:0] size_mask(input logic [1:0] sz);
        return (sz == 2'h3) ? 64'hFFFF_FFFF_FFFF_FFFF : ((64'h1 << (8 << sz)) - 64'h1);
    endfunction

    // ==========================================================
    // handshakes
    // ==========================================================
    // address and data accepted independently
    assign aw_ready = (state == ST_IDLE || state == ST_COLLECT) && !aw_done;
    assign w_ready = (state == ST_IDLE || state == ST_COLLECT) && !wlast_seen;
    assign widx = addr[$clog2(DEPTH)+2:3];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            aw_done <= 1'b0;
            addr <= '0;
            len <= 8'h00;
            size <= 3'h0;
            atop <= ATOP_NONE;
        end else if (aw_valid && aw_ready) begin
            aw_done <= 1'b1;
            addr <= aw_addr;
            len <= aw_len;
            size <= aw_size;
            atop <= aw_atop;
        end else if (state == ST_RESP && b_ready) begin
            aw_done <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wcount <= 2'h0;
            wlast_seen <= 1'b0;
            wbuf[0] <= 64'h0;
            wbuf[1] <= 64'h0;
        end else if (w_valid && w_ready) begin
            // beats beyond two are taken but not kept; wider compares are refused
            if (wcount < 2'h2) begin
                wbuf[wcount[0]] <= w_data;
                wcount <= wcount + 2'h1;
            end
            wlast_seen <= w_last;
        end else if (state == ST_RESP && b_ready) begin
            wcount <= 2'h0;
            wlast_seen <= 1'b0;
        end
    end

    // ==========================================================
    // control sequence
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: if (aw_valid || w_valid) state <= ST_COLLECT;
                // wait for address and last beat
                ST_COLLECT: if (aw_done && wlast_seen) state <= ST_EXEC;
                ST_EXEC: state <= (is_loadlike(atop) && !err) ? ST_READ : ST_RESP;
                ST_READ: if (r_ready && rcount == rbeats - 2'h1) state <= ST_RESP;
                ST_RESP: if (b_ready) state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // only aligned, in-region, single-word operands are supported
    always_comb begin
        err = (atop == ATOP_NONE) || (size > 3'h3) || (aw_addr_hi(addr) > ATOMIC_REGION_LIMIT)
            || (atop == ATOP_COMPARE ? (len > 8'h1) : (len != 8'h0))
            || ((addr & ADDR_W'((1 << size) - 1)) != '0);
    end

    // compare returns half: two beats in, one out
    assign rbeats = 2'h1;

    // sub-word operands sit in their byte lane; the unit sees them moved down
    always_comb begin
        lane_shift = {addr[2:0], 3'h0};
        lane_mask = size_mask(size[1:0]);
        mem_lane = (mem[widx] >> lane_shift) & lane_mask;
        op_lane = (wbuf[0] >> lane_shift) & lane_mask;
    end

    // swap stores the operand, the others the result
    assign new_lane = (atop == ATOP_SWAP) ? op_lane : (alu_out & lane_mask);
    // bytes around the operand keep their value, so a carry never leaks next door
    assign merged = (mem[widx] & ~(lane_mask << lane_shift)) | (new_lane << lane_shift);

    atomic_alu u_alu (
        // low bits operator, bit three byte order
        .op(atop[2:0]),
        .big_endian(atop[ATOP_ENDIAN_BIT]),
        .size_log2(size[1:0]),
        .mem_val(mem_lane),
        .operand(op_lane),
        .result(alu_out)
    );

    // memory updated in exec, before first read beat
    always_ff @(posedge core_clk) begin
        if (state == ST_EXEC && !err) begin
            if (atop == ATOP_COMPARE) begin
                if (mem[widx] == (len == 8'h0 ? wbuf[0] : wbuf[addr[3]])) begin
                    mem[widx] <= (len == 8'h0) ? wbuf[0] : wbuf[~addr[3]];
                end
            end else begin
                mem[widx] <= merged;
            end
        end
    end

    // ==========================================================
    // read and write responses
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rcount <= 2'h0;
            r_data <= 64'h0;
            b_resp <= RESP_OKAY;
        end else begin
            if (state == ST_EXEC) begin
                rcount <= 2'h0;
                r_data <= mem[widx];
                b_resp <= err ? RESP_SLVERR : RESP_OKAY;
            end else if (state == ST_READ && r_ready) begin
                rcount <= rcount + 2'h1;
            end
        end
    end

    // valids driven from state only; after address done
    assign r_valid = (state == ST_READ);
    assign r_resp = RESP_OKAY;
    assign r_last = (state == ST_READ) && (rcount == rbeats - 2'h1);
    assign b_valid = (state == ST_RESP);

    // ==========================================================
    // checks
    // ==========================================================
    a_resp_after_last: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(b_valid) |-> aw_done && wlast_seen) else $error("response before data");
    a_read_after_addr: assert property (@(posedge core_clk) disable iff (sys_rst)
        r_valid |-> aw_done) else $error("read before address");
    a_bvalid_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        b_valid && !b_ready |=> b_valid) else $error("response dropped");
    a_rvalid_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        r_valid && !r_ready |=> r_valid && $stable(r_data)) else $error("read dropped");
    a_one_resp: assert property (@(posedge core_clk) disable iff (sys_rst)
        b_valid && b_ready |=> !b_valid [*2]) else $error("second response");
    a_store_no_read: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_EXEC) && atop[5:4] == ATOP_KIND_STORE |=> !r_valid) else $error("store read");
    a_err_resp: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_EXEC) && err |=> b_valid && b_resp == RESP_SLVERR) else $error("no error");
    a_read_prior: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_EXEC) && !err && is_loadlike(atop) |=> r_valid && r_data == $past(mem[widx]))
        else $error("wrong read data");
    c_load: cover property (@(posedge core_clk) r_valid && r_ready && r_last);
    c_store: cover property (@(posedge core_clk) b_valid && b_ready && b_resp == RESP_OKAY);
    c_error: cover property (@(posedge core_clk) b_valid && b_resp == RESP_SLVERR);
endmodule // atomic_slave

// ===== logic/atomic_pkg.sv
package atomic_pkg;
    // ==========================================================
    // atomic operation field encodings
    // ==========================================================
    localparam logic [5:0] ATOP_NONE = 6'h00;
    localparam logic [1:0] ATOP_KIND_STORE = 2'h1;
    localparam logic [1:0] ATOP_KIND_LOAD = 2'h2;
    localparam logic [5:0] ATOP_SWAP = 6'h30;
    localparam logic [5:0] ATOP_COMPARE = 6'h31;
    localparam int ATOP_ENDIAN_BIT = 3;
    localparam logic [2:0] OP_ADD = 3'h0;
    localparam logic [2:0] OP_CLR = 3'h1;
    localparam logic [2:0] OP_EOR = 3'h2;
    localparam logic [2:0] OP_SET = 3'h3;
    localparam logic [2:0] OP_SMAX = 3'h4;
    localparam logic [2:0] OP_SMIN = 3'h5;
    localparam logic [2:0] OP_UMAX = 3'h6;
    localparam logic [2:0] OP_UMIN = 3'h7;
    // ==========================================================
    // response codes and atomic region bounds
    // ==========================================================
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] ATOMIC_REGION_BASE = 8'h00;
    localparam logic [7:0] ATOMIC_REGION_LIMIT = 8'h7F;
endpackage

// ===== logic/atomic_alu.sv
`timescale 1ns/10ps
// ==========================================================
// combinational operator unit, 64-bit operand
// ==========================================================
module atomic_alu
    import atomic_pkg::*;
(
    input wire logic [2:0] op,
    input wire logic big_endian,
    input wire logic [1:0] size_log2,
    input wire logic [63:0] mem_val,
    input wire logic [63:0] operand,
    output logic [63:0] result
);
    function automatic logic [63:0] swap_bytes(input logic [63:0] v, input logic [1:0] sz);
        logic [63:0] r;
        r = v;
        for (int i = 0; i < 8; i++) begin
            if (i < (1 << sz)) begin
                r[i*8 +: 8] = v[((1 << sz) - 1 - i)*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [63:0] sext(input logic [63:0] v, input logic [1:0] sz);
        logic [63:0] r;
        r = v;
        unique case (sz)
            2'h0: r = {{56{v[7]}}, v[7:0]};
            2'h1: r = {{48{v[15]}}, v[15:0]};
            2'h2: r = {{32{v[31]}}, v[31:0]};
            2'h3: r = v;
        endcase
        return r;
    endfunction

    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] res_n;
    logic arith;

    always_comb begin
        arith = (op == OP_ADD) || op[2];
        a = (arith && big_endian) ? swap_bytes(mem_val, size_log2) : mem_val;
        b = (arith && big_endian) ? swap_bytes(operand, size_log2) : operand;
        unique case (op)
            OP_ADD: res_n = a + b;
            OP_CLR: res_n = a & ~b;
            OP_EOR: res_n = a ^ b;
            OP_SET: res_n = a | b;
            OP_SMAX: res_n = ($signed(sext(a, size_log2)) > $signed(sext(b, size_log2))) ? a : b;
            OP_SMIN: res_n = ($signed(sext(a, size_log2)) < $signed(sext(b, size_log2))) ? a : b;
            OP_UMAX: res_n = (a > b) ? a : b;
            OP_UMIN: res_n = (a < b) ? a : b;
        endcase
        result = (arith && big_endian) ? swap_bytes(res_n, size_log2) : res_n;
    end
endmodule // atomic_alu

// ===== sim/atomic_master_model.sv
`timescale 1ns/10ps
// ==========================================================
// master model, one atomic at a time, up to two write beats
// ==========================================================
module atomic_master_model (
    input wire logic core_clk,
    output logic aw_valid,
    input wire logic aw_ready,
    output logic [11:0] aw_addr,
    output logic [7:0] aw_len,
    output logic [2:0] aw_size,
    output logic [5:0] aw_atop,
    output logic [3:0] aw_snoop,
    output logic aw_lock,
    output logic w_valid,
    input wire logic w_ready,
    output logic [63:0] w_data,
    output logic w_last,
    input wire logic b_valid,
    output logic b_ready,
    input wire logic [1:0] b_resp,
    input wire logic r_valid,
    output logic r_ready,
    input wire logic [63:0] r_data,
    input wire logic [1:0] r_resp,
    input wire logic r_last,
    input wire logic atomics_allowed
);
    logic [63:0] rd;
    logic [1:0] rr;
    logic rl;
    logic [1:0] bresp;
    int nr;
    initial begin
        {aw_valid, w_valid, aw_addr, aw_len, aw_size, aw_atop, aw_snoop} = '0;
        {aw_lock, w_data, w_last, b_ready, r_ready} = '0;
    end
    task automatic run(input logic [5:0] atop, input logic [11:0] addr, input logic [2:0] size,
            input logic [7:0] len, input logic [63:0] d0, input logic [63:0] d1,
            input int aw_wait, input int stall);
        logic awt;
        logic wt;
        logic bt;
        nr = 0;
        bt = 1'b0;
        @(negedge core_clk);
        // strap low: nothing issued, marked by a code this slave never gives
        if (!atomics_allowed) begin
            bresp = 2'h1;
            return;
        end
        aw_snoop = 4'h0;
        aw_lock = 1'b0;
        {aw_addr, aw_len, aw_size, aw_atop} = {addr, len, size, atop};
        // write data valid up at once, address valid after aw_wait cycles, reads never awaited
        aw_valid = (aw_wait == 0);
        w_valid = 1'b1;
        w_data = d0;
        w_last = (len == 8'h00);
        for (int k = 0; k < 200 && !bt; k++) begin
            @(posedge core_clk);
            awt = aw_valid && aw_ready;
            wt = w_valid && w_ready;
            if (r_valid && r_ready) begin
                nr++;
                rd = r_data;
                rr = r_resp;
                rl = r_last;
            end
            bt = b_valid && b_ready;
            if (bt) bresp = b_resp;
            @(negedge core_clk);
            // released lines show the inverse so stale values never match
            if (awt) begin
                aw_valid = 1'b0;
                aw_addr = ~aw_addr;
            end
            if (k + 1 == aw_wait) aw_valid = 1'b1;
            if (wt && w_last) begin
                w_valid = 1'b0;
                w_data = ~w_data;
            end else if (wt) begin
                w_data = d1;
                w_last = 1'b1;
            end
            r_ready = (stall == 0) || (k % 3 == 2);
            b_ready = r_ready;
        end
        if (!bt) bresp = 2'h3;
    endtask
endmodule // atomic_master_model

// ===== sim/atomic_write_channel_ops_tb_top.sv
`timescale 1ns/10ps
module atomic_write_channel_ops_tb_top;
    import atomic_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic aw_valid, aw_ready, aw_lock, w_valid, w_ready, w_last, b_valid, b_ready;
    logic r_valid, r_ready, r_last;
    logic [11:0] aw_addr;
    logic [7:0] aw_len;
    logic [2:0] aw_size;
    logic [5:0] aw_atop;
    logic [3:0] aw_snoop;
    logic [63:0] w_data, r_data;
    logic [1:0] b_resp, r_resp;
    int fails = 0;
    int samples_checked = 0;
    logic atomics_allowed = 1'b1;
    always #20 core_clk = ~core_clk;
    atomic_slave #(.ADDR_W(12), .DEPTH(64)) i_atomic_slave (.core_clk, .sys_rst, .aw_valid,
        .aw_ready, .aw_addr, .aw_len, .aw_size, .aw_atop, .aw_snoop, .aw_lock, .w_valid,
        .w_ready, .w_data, .w_last, .b_valid, .b_ready, .b_resp, .r_valid, .r_ready, .r_data,
        .r_resp, .r_last);
    atomic_master_model i_atomic_master_model (.core_clk, .aw_valid, .aw_ready, .aw_addr,
        .aw_len, .aw_size, .aw_atop, .aw_snoop, .aw_lock, .w_valid, .w_ready, .w_data,
        .w_last, .b_valid, .b_ready, .b_resp, .r_valid, .r_ready, .r_data, .r_resp, .r_last,
        .atomics_allowed);
    // ==========================================================
    // checking helpers
    // ==========================================================
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic [5:0] atop, input logic [11:0] addr, input logic [2:0] size,
            input logic [7:0] len, input logic [63:0] d0, input logic [63:0] d1, input int wt,
            input int st, input int exp_nr, input logic [63:0] exp_rd, input logic [1:0] resp);
        i_atomic_master_model.run(atop, addr, size, len, d0, d1, wt, st);
        check("read beats", 64'(exp_nr), 64'(i_atomic_master_model.nr));
        check("write response", 64'(resp), 64'(i_atomic_master_model.bresp));
        if (exp_nr != 0 && !$isunknown(exp_rd)) begin
            check("read data", exp_rd, i_atomic_master_model.rd);
        end
        if (exp_nr != 0) begin
            check("read last", 64'h1, 64'(i_atomic_master_model.rl));
            check("read response", 64'(RESP_OKAY), 64'(i_atomic_master_model.rr));
        end
    endtask
    function automatic logic [63:0] ref_op(input logic [2:0] op, input logic be,
            input logic [63:0] m, input logic [63:0] d);
        logic sw;
        logic [63:0] a;
        logic [63:0] b;
        logic [63:0] y;
        // byte order matters for arithmetic operators only
        sw = be && (op == OP_ADD || op[2]);
        a = m;
        b = d;
        if (sw) begin
            a = {<<8{m}};
            b = {<<8{d}};
        end
        case (op)
            OP_ADD: y = a + b;
            OP_CLR: y = a & ~b;
            OP_EOR: y = a ^ b;
            OP_SET: y = a | b;
            OP_SMAX: y = ($signed(a) > $signed(b)) ? a : b;
            OP_SMIN: y = ($signed(a) < $signed(b)) ? a : b;
            OP_UMAX: y = (a > b) ? a : b;
            default: y = (a < b) ? a : b;
        endcase
        if (sw) y = {<<8{y}};
        return y;
    endfunction
    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic t_operators();
        logic [63:0] m;
        logic [63:0] d;
        logic [63:0] prev;
        logic [5:0] atop;
        m = 64'h8000_0000_FFFF_0001;
        d = 64'h7FFF_0000_0001_00FF;
        prev = 'x;
        for (int i = 0; i < 16; i++) begin
            atop = {(i[0] ? ATOP_KIND_STORE : ATOP_KIND_LOAD), i[3], i[2:0]};
            xfer(ATOP_SWAP, 12'h020, 3'h3, 8'h00, m, 64'h0, 0, i % 2, 1,
                prev, RESP_OKAY);
            xfer(atop, 12'h020, 3'h3, 8'h00, d, 64'h0, 0, 0, i[0] ? 0 : 1,
                m, RESP_OKAY);
            prev = ref_op(i[2:0], i[3], m, d);
        end
        xfer(ATOP_SWAP, 12'h020, 3'h3, 8'h00, 64'h0, 64'h0, 0, 1, 1, prev, RESP_OKAY);
        $display("operator test done");
    endtask
    task automatic t_compare();
        xfer(ATOP_SWAP, 12'h010, 3'h3, 8'h00, 64'hA5, 64'h0, 0, 0, 1, 'x, RESP_OKAY);
        // compare value first: a match writes the swap value
        xfer(ATOP_COMPARE, 12'h010, 3'h3, 8'h01, 64'hA5, 64'hB6, 3, 1, 1,
            64'hA5, RESP_OKAY);
        xfer(ATOP_COMPARE, 12'h010, 3'h3, 8'h01, 64'hC7, 64'hD8, 0, 0, 1,
            64'hB6, RESP_OKAY);
        // single-beat compare uses one word for both values
        xfer(ATOP_COMPARE, 12'h010, 3'h3, 8'h00, 64'h99, 64'h0, 0, 1, 1,
            64'hB6, RESP_OKAY);
        xfer(ATOP_SWAP, 12'h010, 3'h3, 8'h00, 64'h0, 64'h0, 0, 0, 1,
            64'hB6, RESP_OKAY);
        xfer(ATOP_SWAP, 12'h018, 3'h3, 8'h00, 64'h33, 64'h0, 0, 0, 1, 'x, RESP_OKAY);
        // address off the pair boundary: swap value comes first
        xfer(ATOP_COMPARE, 12'h018, 3'h3, 8'h01, 64'h44, 64'h33, 1, 0, 1,
            64'h33, RESP_OKAY);
        xfer(ATOP_SWAP, 12'h018, 3'h3, 8'h00, 64'h0, 64'h0, 0, 1, 1,
            64'h44, RESP_OKAY);
        $display("compare test done");
    endtask
    task automatic t_subword();
        xfer(ATOP_SWAP, 12'h028, 3'h3, 8'h00, 64'h1111_2222_3333_44FF, 64'h0, 0, 0, 1,
            'x, RESP_OKAY);
        // byte add wraps inside its byte
        xfer({ATOP_KIND_LOAD, 1'b0, OP_ADD}, 12'h028, 3'h0, 8'h00, 64'h01, 64'h0, 0, 0, 1,
            64'h1111_2222_3333_44FF, RESP_OKAY);
        xfer({ATOP_KIND_STORE, 1'b0, OP_SET}, 12'h02A, 3'h1, 8'h00,
            64'h0000_0000_8001_0000, 64'h0, 0, 0, 0, 'x, RESP_OKAY);
        xfer(ATOP_SWAP, 12'h028, 3'h3, 8'h00, 64'h0, 64'h0, 0, 1, 1,
            64'h1111_2222_B333_4400, RESP_OKAY);
        $display("subword test done");
    endtask
    task automatic t_errors();
        logic [28:0] bad [5];
        bad = '{{ATOP_NONE, 12'h020, 3'h3, 8'h00}, {6'h20, 12'h024, 3'h3, 8'h00},
            {6'h20, 12'h020, 3'h4, 8'h00}, {6'h20, 12'h020, 3'h3, 8'h01},
            {ATOP_SWAP, 12'h800, 3'h3, 8'h00}};
        foreach (bad[i]) begin
            xfer(bad[i][28:23], bad[i][22:11], bad[i][10:8], bad[i][7:0], 64'h1, 64'h2, i % 2,
                i % 2, 0, 'x, RESP_SLVERR);
        end
        xfer(ATOP_SWAP, 12'h030, 3'h3, 8'h00, 64'h11, 64'h0, 0, 0, 1, 'x, RESP_OKAY);
        atomics_allowed = 1'b0;
        xfer(ATOP_SWAP, 12'h030, 3'h3, 8'h00, 64'h5A, 64'h0, 0, 0, 0, 'x, 2'h1);
        atomics_allowed = 1'b1;
        xfer(ATOP_SWAP, 12'h030, 3'h3, 8'h00, 64'h0, 64'h0, 0, 0, 1,
            64'h11, RESP_OKAY);
        $display("error test done");
    endtask
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // about 55 transfers, each cut off by the model after 200 cycles; generous margin
    initial begin
        #(40 * 20000);
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        sys_rst = 1'b0;
        t_operators();
        t_compare();
        t_subword();
        t_errors();
        report_and_stop();
    end
endmodule // atomic_write_channel_ops_tb_top
